/* File: core/fndc_pkg.sv */
/*
 fndc_pkg: shared constants and carriers for the fractional-N divider control block.
 assumes: a single clock domain at 200 MHz, and AXI4-Lite register access with 32-bit data.
*/
package fndc_pkg;
   // ===========================================
   // register byte addresses
   localparam logic [7:0] FNDC_ADDR_FIRST_CFG = 8'h00;
   localparam logic [7:0] FNDC_ADDR_INT = 8'h04;
   localparam logic [7:0] FNDC_ADDR_NUM = 8'h08;
   localparam logic [7:0] FNDC_ADDR_DEN = 8'h0C;
   localparam logic [7:0] FNDC_ADDR_REFDIV = 8'h10;
   localparam logic [7:0] FNDC_ADDR_OUTDIV = 8'h14;
   localparam logic [7:0] FNDC_ADDR_STATUS = 8'h18;
   // ===========================================
   // first_config_word field positions
   localparam int FNDC_ORDER_LSB = 0;
   localparam int FNDC_DITH_LSB = 2;
   localparam int FNDC_DBL_BIT = 4;
   localparam int FNDC_CORE_LSB = 8;
   localparam int FNDC_CAP_LSB = 16;
   localparam int FNDC_FREQ_LSB = 24;
   // ===========================================
   // widths, limits and reset values
   localparam int FNDC_FW = 22;
   localparam logic [21:0] FNDC_DEN_MAX = 22'h3FFFFF;
   localparam logic [21:0] FNDC_DEN_RST = 22'h000001;
   localparam logic [15:0] FNDC_INT_RST = 16'h0010;
   localparam logic [11:0] FNDC_REFDIV_RST = 12'h001;
   localparam logic [5:0] FNDC_OUTDIV_RST = 6'h01;
   localparam logic [7:0] FNDC_FREQ_RST = 8'h64;
   localparam logic [1:0] FNDC_RESP_OKAY = 2'h0;
   localparam logic [1:0] FNDC_RESP_SLVERR = 2'h2;
   // ===========================================
   // calibration step time: one capacitor code step per 40 ns, 8 reference ticks
   localparam int FNDC_CLK_MHZ = 200;
   localparam int FNDC_CAL_STEP_NS = 40;
   localparam int FNDC_CAL_STEP_CYC = (FNDC_CAL_STEP_NS * FNDC_CLK_MHZ + 999) / 1000;
   localparam logic [2:0] FNDC_CORE_MAX = 3'h4;
   localparam logic [7:0] FNDC_CAP_MAX = 8'h7F;

   typedef enum logic [1:0] {
      FNDC_ORD_INT = 2'h0,
      FNDC_ORD_1 = 2'h1,
      FNDC_ORD_2 = 2'h2,
      FNDC_ORD_3 = 2'h3
   } fndc_order_t;

   typedef enum logic [2:0] {
      FNDC_CAL_IDLE = 3'b001,
      FNDC_CAL_RUN = 3'b010,
      FNDC_CAL_DONE = 3'b100
   } fndc_cal_t;

   typedef struct packed {
      fndc_order_t order;
      logic [1:0] dither;
      logic doubler;
      logic [2:0] core;
      logic [7:0] cap;
      logic [7:0] freq;
   } fndc_cfg_t;

   typedef struct packed {
      logic [15:0] int_part;
      logic [21:0] num;
      logic [21:0] den;
      fndc_order_t order;
      logic [1:0] dither;
   } fndc_mod_cfg_t;
endpackage

/* File: core/fndc_dsm.sv */
/*
 fndc_dsm: delta-sigma modulator producing the per-cycle feedback divide value.
 assumes: configuration is stable while running; restart pulses from the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module fndc_dsm
   import fndc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic restart,
   input wire fndc_mod_cfg_t cfg,
   output logic [17:0] ndiv
);
   typedef struct packed {
      logic [22:0] a1;
      logic [22:0] a2;
      logic [22:0] a3;
      logic c2d;
      logic [1:0] c3d;
      logic [15:0] lfsr;
      logic [17:0] ndiv;
   } fndc_dsm_st_t;
   fndc_dsm_st_t s_r, s_nxt;

   // modulus add with carry out; den limited to 22 bits
   function automatic logic [23:0] fndc_acc(input logic [22:0] a, input logic [22:0] b,
                                            input logic [21:0] den);
      logic [23:0] sum;
      sum = {1'b0, a} + {1'b0, b};
      if (sum >= {2'b00, den}) begin
         fndc_acc = {1'b1, 23'(sum - {2'b00, den})};
      end else begin
         fndc_acc = {1'b0, sum[22:0]};
      end
   endfunction

   logic [23:0] r1, r2, r3;
   logic [22:0] dnum;
   logic signed [19:0] dn;
   always_comb begin
      s_nxt = s_r;
      s_nxt.lfsr = {s_r.lfsr[14:0], s_r.lfsr[15] ^ s_r.lfsr[13] ^ s_r.lfsr[12] ^ s_r.lfsr[10]};
      // dither adds a small lsb-scaled offset to the fraction input
      unique case (cfg.dither)
         2'h0: dnum = {1'b0, cfg.num};
         2'h1: dnum = {1'b0, cfg.num} + 23'(s_r.lfsr[0]);
         2'h2: dnum = {1'b0, cfg.num} + 23'(s_r.lfsr[1:0]);
         default: dnum = {1'b0, cfg.num} + 23'(s_r.lfsr[3:0]);
      endcase
      if (dnum >= {1'b0, cfg.den}) begin
         dnum = {1'b0, cfg.num};
      end
      r1 = fndc_acc(s_r.a1, dnum, cfg.den);
      r2 = fndc_acc(s_r.a2, r1[22:0], cfg.den);
      r3 = fndc_acc(s_r.a3, r2[22:0], cfg.den);
      // mash cascade, the order picks how many stages feed the output
      unique case (cfg.order)
         FNDC_ORD_1: dn = 20'(r1[23]);
         FNDC_ORD_2: dn = 20'(r1[23]) + 20'(r2[23]) - 20'(s_r.c2d);
         FNDC_ORD_3: dn = 20'(r1[23]) + 20'(r2[23]) - 20'(s_r.c2d) + 20'(r3[23])
                          - 20'(s_r.c3d[0]) - 20'(s_r.c3d[0]) + 20'(s_r.c3d[1]);
         default: dn = 20'sh00000;
      endcase
      if (cfg.order == FNDC_ORD_INT || cfg.den == 22'h000000) begin
         s_nxt.ndiv = {2'b00, cfg.int_part};
      end else begin
         s_nxt.ndiv = 18'(20'({4'h0, cfg.int_part}) + dn);
         s_nxt.a1 = r1[22:0];
         s_nxt.a2 = r2[22:0];
         s_nxt.a3 = r3[22:0];
         s_nxt.c2d = r2[23];
         s_nxt.c3d = {s_r.c3d[0], r3[23]};
      end
      if (restart) begin
         // clearing the accumulators keeps the spur pattern repeatable
         s_nxt = '0;
         s_nxt.lfsr = 16'hACE1;
         s_nxt.ndiv = {2'b00, cfg.int_part};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.lfsr <= 16'hACE1;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign ndiv = s_r.ndiv;
endmodule // fndc_dsm
`default_nettype wire

/* File: core/fndc_top.sv */
/*
 fndc_top: register file and control for a fractional-N synthesizer divider.
 assumes: aclk is the reference clock; one AXI4-Lite master; analog parts outside.
*/
`timescale 1ns/100ps
`default_nettype none
module fndc_top
   import fndc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [17:0] feedback_divide,
   output logic [11:0] ref_divide,
   output logic reference_doubler_factor,
   output logic [5:0] output_divide_ratio,
   output logic [2:0] cal_core,
   output logic [7:0] cal_cap,
   output logic cal_busy,
   output logic modulator_restart
);
   // ===========================================
   // state
   typedef struct packed {
      logic aw_full;
      logic [7:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      fndc_cfg_t cfg;
      logic [15:0] int_part;
      logic [21:0] num;
      logic [21:0] den;
      logic [11:0] refdiv;
      logic [5:0] outdiv;
      logic restart;
      fndc_cal_t cal;
      logic [2:0] core;
      logic [7:0] cap;
      logic [7:0] step;
      logic [15:0] cal_cycles;
      logic awready;
      logic wready;
      logic arready;
   } fndc_st_t;
   fndc_st_t s_r, s_nxt;

   function automatic logic [31:0] fndc_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      fndc_merge = res;
   endfunction

   function automatic logic fndc_mapped(input logic [7:0] a);
      fndc_mapped = (a[1:0] == 2'b00) && (a <= FNDC_ADDR_STATUS);
   endfunction

   logic [17:0] dsm_ndiv;
   fndc_mod_cfg_t mod_cfg;
   assign mod_cfg = '{int_part: s_r.int_part, num: s_r.num, den: s_r.den,
                      order: s_r.cfg.order, dither: s_r.cfg.dither};

   fndc_dsm u_dsm (
      .aclk(aclk),
      .aresetn(aresetn),
      .restart(s_r.restart),
      .cfg(mod_cfg),
      .ndiv(dsm_ndiv)
   );

   logic [31:0] cfg_word, old_word, new_word;
   always_comb begin
      s_nxt = s_r;
      s_nxt.restart = 1'b0;
      cfg_word = {s_r.cfg.freq, s_r.cfg.cap, 5'h00, s_r.cfg.core, 3'h0, s_r.cfg.doubler,
                  s_r.cfg.dither, s_r.cfg.order};
      old_word = 32'h00000000;
      new_word = 32'h00000000;
      // ===========================================
      // write channel: address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         s_nxt.aw_full = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_nxt.w_full = 1'b1;
         s_nxt.w_data = s_axi_wdata;
         s_nxt.w_strb = s_axi_wstrb;
      end
      if (s_r.aw_full && s_r.w_full && !s_r.bvalid) begin
         s_nxt.aw_full = 1'b0;
         s_nxt.w_full = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = fndc_mapped(s_r.aw_addr) && s_r.aw_addr != FNDC_ADDR_STATUS
                       ? FNDC_RESP_OKAY : FNDC_RESP_SLVERR;
         unique case (s_r.aw_addr)
            FNDC_ADDR_FIRST_CFG: old_word = cfg_word;
            FNDC_ADDR_INT: old_word = {16'h0000, s_r.int_part};
            FNDC_ADDR_NUM: old_word = {10'h000, s_r.num};
            FNDC_ADDR_DEN: old_word = {10'h000, s_r.den};
            FNDC_ADDR_REFDIV: old_word = {20'h00000, s_r.refdiv};
            FNDC_ADDR_OUTDIV: old_word = {26'h0000000, s_r.outdiv};
            default: old_word = 32'h00000000;
         endcase
         new_word = fndc_merge(old_word, s_r.w_data, s_r.w_strb);
         unique case (s_r.aw_addr)
            FNDC_ADDR_FIRST_CFG: begin
               s_nxt.cfg.order = fndc_order_t'(new_word[FNDC_ORDER_LSB +: 2]);
               s_nxt.cfg.dither = new_word[FNDC_DITH_LSB +: 2];
               s_nxt.cfg.doubler = new_word[FNDC_DBL_BIT];
               s_nxt.cfg.core = new_word[FNDC_CORE_LSB +: 3];
               s_nxt.cfg.cap = new_word[FNDC_CAP_LSB +: 8];
               s_nxt.cfg.freq = new_word[FNDC_FREQ_LSB +: 8];
               // every write here restarts the modulator and calibration
               s_nxt.restart = 1'b1;
               s_nxt.cal = FNDC_CAL_RUN;
               s_nxt.core = new_word[FNDC_CORE_LSB +: 3] > FNDC_CORE_MAX
                            ? FNDC_CORE_MAX : new_word[FNDC_CORE_LSB +: 3];
               s_nxt.cap = new_word[FNDC_CAP_LSB +: 8] > FNDC_CAP_MAX
                           ? FNDC_CAP_MAX : new_word[FNDC_CAP_LSB +: 8];
               s_nxt.step = 8'h00;
               s_nxt.cal_cycles = 16'h0000;
            end
            FNDC_ADDR_INT: s_nxt.int_part = new_word[15:0];
            FNDC_ADDR_NUM: s_nxt.num = new_word[21:0];
            FNDC_ADDR_DEN: begin
               // zero is not a legal denominator, one stands in for it
               s_nxt.den = new_word[21:0] == 22'h000000 ? FNDC_DEN_RST : new_word[21:0];
            end
            FNDC_ADDR_REFDIV: begin
               s_nxt.refdiv = new_word[11:0] == 12'h000 ? FNDC_REFDIV_RST : new_word[11:0];
            end
            FNDC_ADDR_OUTDIV: begin
               s_nxt.outdiv = new_word[5:0] == 6'h00 ? FNDC_OUTDIV_RST : new_word[5:0];
            end
            default: ;
         endcase
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      // ===========================================
      // read channel
      if (s_axi_arvalid && s_axi_arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = fndc_mapped(s_axi_araddr) ? FNDC_RESP_OKAY : FNDC_RESP_SLVERR;
         unique case (s_axi_araddr)
            FNDC_ADDR_FIRST_CFG: s_nxt.rdata = cfg_word;
            FNDC_ADDR_INT: s_nxt.rdata = {16'h0000, s_r.int_part};
            FNDC_ADDR_NUM: s_nxt.rdata = {10'h000, s_r.num};
            FNDC_ADDR_DEN: s_nxt.rdata = {10'h000, s_r.den};
            FNDC_ADDR_REFDIV: s_nxt.rdata = {20'h00000, s_r.refdiv};
            FNDC_ADDR_OUTDIV: s_nxt.rdata = {26'h0000000, s_r.outdiv};
            FNDC_ADDR_STATUS: begin
               s_nxt.rdata = {s_r.cal_cycles, s_r.cap, 1'b0, s_r.core,
                              2'b00, s_r.cal == FNDC_CAL_DONE, s_r.cal == FNDC_CAL_RUN};
            end
            default: s_nxt.rdata = 32'h00000000;
         endcase
      end
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      // ===========================================
      // calibration walk: down the capacitor codes, then the next core.
      // the real band compare is analog; here the walk ends at code zero of the top core,
      // so a start near the end gives a short calibration
      if (s_r.cal == FNDC_CAL_RUN && !s_nxt.restart) begin
         s_nxt.cal_cycles = s_r.cal_cycles + 16'h0001;
         if (s_r.step == 8'(FNDC_CAL_STEP_CYC - 1)) begin
            s_nxt.step = 8'h00;
            if (s_r.cap != 8'h00) begin
               s_nxt.cap = s_r.cap - 8'h01;
            end else if (s_r.core < FNDC_CORE_MAX) begin
               s_nxt.core = s_r.core + 3'h1;
               s_nxt.cap = FNDC_CAP_MAX;
            end else begin
               s_nxt.cal = FNDC_CAL_DONE;
            end
         end else begin
            s_nxt.step = s_r.step + 8'h01;
         end
      end
      // readies are registered so the bus outputs come straight from flops
      s_nxt.awready = !s_nxt.aw_full;
      s_nxt.wready = !s_nxt.w_full;
      s_nxt.arready = !s_nxt.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.cfg.freq <= FNDC_FREQ_RST;
         s_r.int_part <= FNDC_INT_RST;
         s_r.den <= FNDC_DEN_RST;
         s_r.refdiv <= FNDC_REFDIV_RST;
         s_r.outdiv <= FNDC_OUTDIV_RST;
         s_r.cal <= FNDC_CAL_IDLE;
         s_r.awready <= 1'b1;
         s_r.wready <= 1'b1;
         s_r.arready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ===========================================
   // outputs, all from flip-flops; the analog path applies the ratios
   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign feedback_divide = dsm_ndiv;
   assign ref_divide = s_r.refdiv;
   assign reference_doubler_factor = s_r.cfg.doubler;
   assign output_divide_ratio = s_r.outdiv;
   assign cal_core = s_r.core;
   assign cal_cap = s_r.cap;
   assign cal_busy = s_r.cal[1]; // run bit of the one-hot code
   assign modulator_restart = s_r.restart;
endmodule // fndc_top
`default_nettype wire

/* File: verification/fndc_properties.sv */
/*
 fndc_properties: concurrent checks on the divider control ports.
 assumes: bound to fndc_top; config and ref divide writes use all strobes.
*/
`timescale 1ns/100ps
`default_nettype none
module fndc_properties
   import fndc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [11:0] ref_divide,
   input wire logic reference_doubler_factor,
   input wire logic [2:0] cal_core,
   input wire logic [7:0] cal_cap,
   input wire logic cal_busy,
   input wire logic modulator_restart
);
   // ===========================================
   // last taken address and data; the slave blocks new ones until the response
   logic [7:0] aw_r;
   logic [31:0] wd_r;
   always_ff @(posedge aclk) begin
      if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ===========================================
   // properties
   property p_restart_on_cfg;
      $rose(s_axi_bvalid) && aw_r == FNDC_ADDR_FIRST_CFG |-> modulator_restart;
   endproperty
   a_restart_on_cfg: assert property (p_restart_on_cfg) else $error("no restart");
   property p_restart_cause;
      modulator_restart |-> $rose(s_axi_bvalid) && aw_r == FNDC_ADDR_FIRST_CFG;
   endproperty
   a_restart_cause: assert property (p_restart_cause) else $error("stray restart");
   property p_restart_pulse;
      modulator_restart |=> !modulator_restart;
   endproperty
   a_restart_pulse: assert property (p_restart_pulse) else $error("long restart");
   property p_cal_start;
      modulator_restart |-> cal_busy
         && cal_core == ((wd_r[10:8] > FNDC_CORE_MAX) ? FNDC_CORE_MAX : wd_r[10:8])
         && cal_cap == ((wd_r[23:16] > FNDC_CAP_MAX) ? FNDC_CAP_MAX : wd_r[23:16]);
   endproperty
   a_cal_start: assert property (p_cal_start) else $error("bad cal start");
   property p_doubler;
      modulator_restart |-> reference_doubler_factor == wd_r[FNDC_DBL_BIT];
   endproperty
   a_doubler: assert property (p_doubler) else $error("doubler mismatch");
   property p_refdiv;
      $rose(s_axi_bvalid) && aw_r == FNDC_ADDR_REFDIV |-> ref_divide == wd_r[11:0];
   endproperty
   a_refdiv: assert property (p_refdiv) else $error("ref divide mismatch");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   property p_ranswer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_ranswer: assert property (p_ranswer) else $error("read not answered");
endmodule // fndc_properties

bind fndc_top fndc_properties u_props (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .ref_divide(ref_divide), .cal_core(cal_core),
   .reference_doubler_factor(reference_doubler_factor), .cal_cap(cal_cap),
   .cal_busy(cal_busy), .modulator_restart(modulator_restart)
);
`default_nettype wire

/* File: verification/tb_top.sv */
/*
 tb_top: self-checking bench for fndc_top over its AXI4-Lite port.
 assumes: one 200 MHz clock; synchronous active-low reset held 16 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import fndc_pkg::*;
   // ===========================================
   // stimulus and observation
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [17:0] feedback_divide;
   logic [11:0] ref_divide;
   logic [5:0] output_divide_ratio;
   logic [2:0] cal_core;
   logic [7:0] cal_cap;
   logic reference_doubler_factor, cal_busy, modulator_restart;
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   fndc_top uut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .feedback_divide(feedback_divide), .ref_divide(ref_divide),
      .reference_doubler_factor(reference_doubler_factor),
      .output_divide_ratio(output_divide_ratio), .cal_core(cal_core), .cal_cap(cal_cap),
      .cal_busy(cal_busy), .modulator_restart(modulator_restart)
   );
   always #2.5 aclk = ~aclk;
   // ===========================================
   // verdict, hang guard and compare
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         $display("FAIL %0t timeout", $time);
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // ===========================================
   // bus tasks; each ends one edge after the answer so no signal is set twice at one time
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      // ready follows valid one edge late so the answer hold is exercised
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      rd = s_axi_rdata;
      chk({30'h0, s_axi_rresp}, {30'h0, er}, "read resp");
      s_axi_rready <= 1'b0;
      @(posedge aclk);
      chk(rd, exp, "read data");
   endtask
   function automatic logic [31:0] cfgw(logic [1:0] o, logic [1:0] d, logic [2:0] c,
                                         logic [7:0] cap, logic dbl);
      return {FNDC_FREQ_RST, cap, 5'h0, c, 3'h0, dbl, d, o};
   endfunction
   // ===========================================
   // scenarios
   task automatic t_reset();
      rchk(FNDC_ADDR_FIRST_CFG, {FNDC_FREQ_RST, 24'h0}, FNDC_RESP_OKAY);
      rchk(FNDC_ADDR_INT, {16'h0, FNDC_INT_RST}, FNDC_RESP_OKAY);
      rchk(FNDC_ADDR_NUM, 32'h0, FNDC_RESP_OKAY);
      rchk(FNDC_ADDR_DEN, {10'h0, FNDC_DEN_RST}, FNDC_RESP_OKAY);
      rchk(FNDC_ADDR_REFDIV, {20'h0, FNDC_REFDIV_RST}, FNDC_RESP_OKAY);
      rchk(FNDC_ADDR_OUTDIV, {26'h0, FNDC_OUTDIV_RST}, FNDC_RESP_OKAY);
      chk({14'h0, feedback_divide}, {16'h0, FNDC_INT_RST}, "reset divide");
      chk({26'h0, output_divide_ratio}, {26'h0, FNDC_OUTDIV_RST}, "outdiv pin");
      $display("test reset done");
   endtask
   task automatic t_regs();
      wr(FNDC_ADDR_DEN, 32'h0, 4'hF);
      rchk(FNDC_ADDR_DEN, 32'h1, FNDC_RESP_OKAY);
      wr(FNDC_ADDR_DEN, 32'hFFFFFFFF, 4'hF);
      rchk(FNDC_ADDR_DEN, {10'h0, FNDC_DEN_MAX}, FNDC_RESP_OKAY);
      wr(FNDC_ADDR_NUM, 32'h12345678, 4'h3);
      rchk(FNDC_ADDR_NUM, 32'h00005678, FNDC_RESP_OKAY);
      wr(FNDC_ADDR_REFDIV, 32'h00000ABC, 4'hF);
      chk({20'h0, ref_divide}, 32'h00000ABC, "ref divide");
      wr(FNDC_ADDR_OUTDIV, 32'h00000026, 4'hF);
      chk({26'h0, output_divide_ratio}, 32'h00000026, "out divide");
      wr(FNDC_ADDR_STATUS, 32'h5, 4'hF);
      chk({30'h0, rsp}, {30'h0, FNDC_RESP_SLVERR}, "status write");
      rchk(8'h1C, 32'h0, FNDC_RESP_SLVERR);
      rchk(8'h02, 32'h0, FNDC_RESP_SLVERR);
      $display("test regs done");
   endtask
   task automatic t_int();
      int bad;
      bad = 0;
      wr(FNDC_ADDR_INT, 32'd100, 4'hF);
      wr(FNDC_ADDR_NUM, 32'd5, 4'hF);
      wr(FNDC_ADDR_DEN, 32'd7, 4'hF);
      wr(FNDC_ADDR_FIRST_CFG, cfgw(2'h0, 2'h0, 3'h4, 8'h00, 1'b0), 4'hF);
      repeat (40) begin
         @(posedge aclk);
         if (feedback_divide !== 18'd100) bad++;
      end
      chk(bad, 0, "integer mode");
      $display("test integer done");
   endtask
   // a window of 400 samples spans 100 periods of 1/4, so its sum is 400*50+100
   task automatic t_frac();
      int s[2];
      int h[2];
      wr(FNDC_ADDR_INT, 32'd50, 4'hF);
      wr(FNDC_ADDR_NUM, 32'd1, 4'hF);
      wr(FNDC_ADDR_DEN, 32'd4, 4'hF);
      for (int o = 1; o < 4; o++) begin
         for (int k = 0; k < 2; k++) begin
            wr(FNDC_ADDR_FIRST_CFG, cfgw(o[1:0], 2'h0, 3'h4, 8'h00, 1'b0), 4'hF);
            s[k] = 0;
            h[k] = 0;
            repeat (400) begin
               @(posedge aclk);
               s[k] += feedback_divide;
               h[k] = h[k] * 31 + feedback_divide;
            end
         end
         chk(h[1], h[0], "restart repeat");
         chk(s[0] >= 20090 && s[0] <= 20110, 1, "fraction mean");
      end
      for (int d = 1; d < 4; d++) begin
         wr(FNDC_ADDR_FIRST_CFG, cfgw(2'h3, d[1:0], 3'h4, 8'h00, 1'b0), 4'hF);
         s[0] = 0;
         repeat (400) begin
            @(posedge aclk);
            s[0] += feedback_divide;
         end
         chk(s[0] >= 20105 && s[0] <= 20800, 1, "dither mean");
      end
      $display("test fraction done");
   endtask
   // one cap step per 8 cycles: a near start is short, core 3 code 127 runs two full sweeps
   task automatic t_cal();
      int n;
      int m;
      n = 0;
      m = 0;
      wr(FNDC_ADDR_FIRST_CFG, cfgw(2'h0, 2'h0, 3'h4, 8'd15, 1'b1), 4'hF);
      chk({31'h0, reference_doubler_factor}, 32'h1, "doubler");
      while (cal_busy) begin
         @(posedge aclk);
         n++;
      end
      chk(n >= 100 && n <= 140, 1, "near cal time");
      rchk(FNDC_ADDR_STATUS, 32'h00800042, FNDC_RESP_OKAY);
      chk(rd[15:0], 16'h0042, "cal end state");
      wr(FNDC_ADDR_FIRST_CFG, cfgw(2'h0, 2'h0, 3'h3, 8'd127, 1'b0), 4'hF);
      while (cal_busy) begin
         @(posedge aclk);
         m++;
      end
      chk(m >= 1980 && m <= 2080, 1, "far cal time");
      $display("test calibration done");
   endtask
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_regs();
      t_int();
      t_frac();
      t_cal();
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
